// ### rtl/mmd_consts.svh
// Address map, register layout and reset constants of the memory map decoder
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
`define MMD_INTERNAL_DATA_SPACE_HALF_BIT   7
`define MMD_PCR_OFFSET       8'h87
`define MMD_PCR_RESET        8'h00
`define MMD_PCR_BAUD_BIT     7
`define MMD_PCR_PD_BIT       1
`define MMD_PCR_RSV0_BIT     0
`define MMD_PCR_WMASK        8'h83
`define MMD_PAGE_OFFSET      8'hFA
`define MMD_PAGE_RESET       8'h00
`define MMD_EXTENDED_RAM_SPACE_RAM_END     16'h5FFF
`define MMD_EXTENDED_RAM_SPACE_VALID_END   16'h03C7
`define MMD_PERIPH_BASE      16'h6000
`define MMD_PERIPH_END       16'h7FFF
`define MMD_IOCFG_PAGE       8'h61
`define MMD_PCRX_PAGE        8'h62
`define MMD_CIU_PAGE         8'h63
`define MMD_CIU_LAST_LOW     8'h3F
`define MMD_ROM_END          16'hAFFF
`endif

// ### rtl/mmd_pkg.sv
// Types shared by the memory map decoder
package mmd_pkg;
  typedef enum logic [2:0] {
    MMD_INTERNAL_DATA_SPACE_LOWER,
    MMD_INTERNAL_DATA_SPACE_UPPER,
    MMD_INTERNAL_DATA_SPACE_SPECIAL
  } mmd_internal_data_space_sel_e;

  typedef enum logic [2:0] {
    MMD_XSEL_NONE,
    MMD_XSEL_RAM,
    MMD_XSEL_IOCFG,
    MMD_XSEL_PCR,
    MMD_XSEL_CIU
  } mmd_extended_ram_space_sel_e;

  typedef enum {
    MMD_RUN,
    MMD_POWER_DOWN
  } mmd_pwr_e;
endpackage

// ### rtl/mmd_top.sv
// Memory map decoder with power control and page registers
//
// Function
// [R1] Addresses 00h-7Fh select lower internal RAM in both addressing modes.
// [R2] Direct addresses 80h-FFh go to the special register space.
// [R3] Indirect addresses 80h-FFh go to upper internal RAM.
// [R4] Direct mode uses the one-byte address field of the instruction.
// [R5] Indirect mode uses the named pointer register's contents as address.
// [R6] Internal data space spans 384 bytes, 128 of them special registers.
// [R7] Extended space is one 64 KB bank with 16-bit addresses.
// [R8] Extended 0000h-5FFFh is RAM; only 0000h-03C7h reaches physical RAM.
// [R9] Extended 6000h-7FFFh is peripheral space of 32 regions, 256 bytes.
// [R10] Region 6100h-61FFh selects I/O and configuration registers.
// [R11] Region 6200h-62FFh selects power, clock and reset registers.
// [R12] 6300h-633Fh selects contactless unit; 6000h-60FFh and 6340h up reserved.
// [R13] Data pointer moves reach every extended address.
// [R14] Paged moves use page register high byte, pointer register low byte.
// [R15] Program fetches 0000h-AFFFh map onto the 44 KB ROM.
// [R16] Power control bit 7 doubles the debug serial baud rate.
// [R17] Writing 1 to power control bit 1 enters power-down.
// [R18] Power control bits 6-2 read-only; all bits reset to 0.
// [R19] Software keeps power control bit 0 at 0 when writing.
// [R20] An enabled interrupt wakes the core from power-down.
// [R21] Reserved or out-of-range extended accesses ignore writes, read zero.
`include "mmd_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module mmd_top (
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // Internal data access
  input  wire logic        internal_data_space_req_in,
  input  wire logic        internal_data_space_we_in,
  input  wire logic        internal_data_space_indirect_in,
  input  wire logic [7:0]  internal_data_space_field_in,
  input  wire logic [7:0]  internal_data_space_ptr_in,
  input  wire logic [7:0]  internal_data_space_wdata_in,
  // Extended data access
  input  wire logic        extended_ram_space_req_in,
  input  wire logic        extended_ram_space_we_in,
  input  wire logic        extended_ram_space_paged_in,
  input  wire logic [15:0] data_pointer_16_in,
  input  wire logic        extended_ram_space_ptr_sel_in,
  input  wire logic [7:0]  pointer_reg_zero_in,
  input  wire logic [7:0]  pointer_reg_one_in,
  input  wire logic [7:0]  extended_ram_space_wdata_in,
  input  wire logic [7:0]  extended_ram_space_rdata_in,
  // Program fetch
  input  wire logic        fetch_req_in,
  input  wire logic [15:0] fetch_addr_in,
  // Wake source
  input  wire logic        irq_enabled_in,
  // Internal data side outputs
  output logic             internal_data_space_lower_sel_out,
  output logic             internal_data_space_upper_sel_out,
  output logic             special_sel_out,
  output logic [7:0]       internal_data_space_addr_out,
  output logic             internal_data_space_we_out,
  output logic [7:0]       internal_data_space_wdata_out,
  output logic [7:0]       special_rdata_out,
  // Extended side outputs
  output logic [15:0]      extended_ram_space_addr_out,
  output logic             extended_ram_space_ram_sel_out,
  output logic             extended_ram_space_iocfg_sel_out,
  output logic             extended_ram_space_pcr_sel_out,
  output logic             extended_ram_space_ciu_sel_out,
  output logic             extended_ram_space_we_out,
  output logic [7:0]       extended_ram_space_wdata_out,
  output logic [7:0]       extended_ram_space_rdata_out,
  // Program side outputs
  output logic             rom_sel_out,
  output logic [15:0]      rom_addr_out,
  // Power control outputs
  output logic             baud_double_out,
  output logic             cpu_power_down_out
);

  typedef struct packed {
    logic [7:0]              power_control_reg;
    logic [7:0]              ext_page_high_byte;
    mmd_pkg::mmd_pwr_e       pwr;
    logic                    lower_sel;
    logic                    upper_sel;
    logic                    special_sel;
    logic [7:0]              iaddr;
    logic                    iwe;
    logic [7:0]              iwdata;
    logic [7:0]              srdata;
    logic [15:0]             xaddr;
    mmd_pkg::mmd_extended_ram_space_sel_e  xsel;
    logic                    xwe;
    logic [7:0]              xwdata;
    logic [7:0]              xrdata;
    logic                    rom_sel;
    logic [15:0]             rom_addr;
    logic                    ram_sel;
    logic                    iocfg_sel;
    logic                    pcr_sel;
    logic                    ciu_sel;
    logic                    pd;
  } mmd_state_s;

  mmd_state_s state_ff;
  mmd_state_s nxt_state;

  // Address and addressing mode to internal data block
  function automatic mmd_pkg::mmd_internal_data_space_sel_e internal_data_space_decode(
    input logic [7:0] a,
    input logic       indirect
  );
    mmd_pkg::mmd_internal_data_space_sel_e s;
    if (!a[`MMD_INTERNAL_DATA_SPACE_HALF_BIT]) begin
      s = mmd_pkg::MMD_INTERNAL_DATA_SPACE_LOWER; // [R1]
    end else if (indirect) begin
      s = mmd_pkg::MMD_INTERNAL_DATA_SPACE_UPPER; // [R3]
    end else begin
      s = mmd_pkg::MMD_INTERNAL_DATA_SPACE_SPECIAL; // [R2]
    end
    return s;
  endfunction

  // Read value of the locally held special registers
  function automatic logic [7:0] special_read(
    input logic [7:0] a,
    input logic [7:0] pcr,
    input logic [7:0] page
  );
    logic [7:0] d;
    // Other special addresses live outside this block and read zero here
    d = 8'h00;
    if (a == `MMD_PCR_OFFSET) begin
      d = pcr;
    end else if (a == `MMD_PAGE_OFFSET) begin
      d = page;
    end
    return d;
  endfunction

  // Extended address to target region
  function automatic mmd_pkg::mmd_extended_ram_space_sel_e extended_ram_space_decode(input logic [15:0] a);
    mmd_pkg::mmd_extended_ram_space_sel_e s;
    s = mmd_pkg::MMD_XSEL_NONE;
    if (a <= `MMD_EXTENDED_RAM_SPACE_VALID_END) begin
      s = mmd_pkg::MMD_XSEL_RAM; // [R8]
    end else if (a <= `MMD_EXTENDED_RAM_SPACE_RAM_END) begin
      s = mmd_pkg::MMD_XSEL_NONE; // [R21]
    end else if (a <= `MMD_PERIPH_END) begin
      case (a[15:8]) // [R9]
        `MMD_IOCFG_PAGE: s = mmd_pkg::MMD_XSEL_IOCFG; // [R10]
        `MMD_PCRX_PAGE:  s = mmd_pkg::MMD_XSEL_PCR; // [R11]
        `MMD_CIU_PAGE: begin
          if (a[7:0] <= `MMD_CIU_LAST_LOW) begin
            s = mmd_pkg::MMD_XSEL_CIU; // [R12]
          end
        end
        default: s = mmd_pkg::MMD_XSEL_NONE; // [R12]
      endcase
    end
    return s;
  endfunction

  logic [7:0]             ieff_addr;
  mmd_pkg::mmd_internal_data_space_sel_e isel_now;
  logic [15:0]            xeff_addr;
  mmd_pkg::mmd_extended_ram_space_sel_e xsel_now;
  logic                   pcr_hit;
  logic                   page_hit;

  always_comb begin
    nxt_state = state_ff;
    // Indirect takes the pointer contents, direct the instruction field
    ieff_addr = internal_data_space_indirect_in ? internal_data_space_ptr_in : internal_data_space_field_in; // [R4] [R5]
    // Page form builds the address; pointer form reaches all 64 KB
    xeff_addr = extended_ram_space_paged_in
      ? {state_ff.ext_page_high_byte,
         (extended_ram_space_ptr_sel_in ? pointer_reg_one_in : pointer_reg_zero_in)} // [R14]
      : data_pointer_16_in; // [R7] [R13]
    xsel_now = extended_ram_space_decode(xeff_addr);
    isel_now = internal_data_space_decode(ieff_addr, internal_data_space_indirect_in);
    pcr_hit  = 1'b0;
    page_hit = 1'b0;

    // Internal data steering, 256 addresses fan out to 384 bytes
    nxt_state.lower_sel   = 1'b0;
    nxt_state.upper_sel   = 1'b0;
    nxt_state.special_sel = 1'b0;
    nxt_state.iwe         = 1'b0;
    nxt_state.iaddr       = ieff_addr;
    nxt_state.iwdata      = internal_data_space_wdata_in;
    nxt_state.srdata      = 8'h00;
    if (internal_data_space_req_in) begin
      nxt_state.iwe = internal_data_space_we_in;
      case (isel_now)
        mmd_pkg::MMD_INTERNAL_DATA_SPACE_LOWER: begin
          nxt_state.lower_sel = 1'b1; // [R1]
        end
        mmd_pkg::MMD_INTERNAL_DATA_SPACE_UPPER: begin
          nxt_state.upper_sel = 1'b1; // [R3] [R6]
        end
        mmd_pkg::MMD_INTERNAL_DATA_SPACE_SPECIAL: begin
          nxt_state.special_sel = 1'b1; // [R2] [R6]
          pcr_hit  = (ieff_addr == `MMD_PCR_OFFSET);
          page_hit = (ieff_addr == `MMD_PAGE_OFFSET);
          nxt_state.srdata = special_read(ieff_addr, state_ff.power_control_reg,
                                          state_ff.ext_page_high_byte);
        end
        default: begin
          nxt_state.lower_sel = 1'b0;
        end
      endcase
    end

    // Local special registers
    if (pcr_hit && internal_data_space_we_in) begin
      // Only bits 7, 1 and 0 take writes; bit 0 is kept clear by software
      nxt_state.power_control_reg = internal_data_space_wdata_in & `MMD_PCR_WMASK; // [R18] [R19]
    end
    if (page_hit && internal_data_space_we_in) begin
      nxt_state.ext_page_high_byte = internal_data_space_wdata_in;
    end

    // Power state: a wake interrupt beats a same-cycle power-down write
    case (state_ff.pwr)
      mmd_pkg::MMD_RUN: begin
        if (pcr_hit && internal_data_space_we_in && internal_data_space_wdata_in[`MMD_PCR_PD_BIT] && !irq_enabled_in) begin
          nxt_state.pwr = mmd_pkg::MMD_POWER_DOWN; // [R17]
        end else if (pcr_hit && internal_data_space_we_in) begin
          nxt_state.power_control_reg[`MMD_PCR_PD_BIT] = 1'b0; // [R20]
        end
      end
      mmd_pkg::MMD_POWER_DOWN: begin
        if (irq_enabled_in) begin
          nxt_state.pwr = mmd_pkg::MMD_RUN; // [R20]
          nxt_state.power_control_reg[`MMD_PCR_PD_BIT] = 1'b0; // [R20]
        end
      end
      default: nxt_state.pwr = mmd_pkg::MMD_RUN;
    endcase
    // Level flag kept in a flop so the pin never glitches on decode
    nxt_state.pd = (nxt_state.pwr == mmd_pkg::MMD_POWER_DOWN); // [R17]

    // Extended data steering
    nxt_state.xaddr  = xeff_addr;
    nxt_state.xwdata = extended_ram_space_wdata_in;
    nxt_state.xsel   = mmd_pkg::MMD_XSEL_NONE;
    nxt_state.xwe    = 1'b0;
    if (extended_ram_space_req_in) begin
      nxt_state.xsel = xsel_now;
      // Unmapped targets never see a write strobe
      nxt_state.xwe  = extended_ram_space_we_in && (xsel_now != mmd_pkg::MMD_XSEL_NONE); // [R21]
    end
    // One-hot selects held in flops so the outputs leave straight from them
    nxt_state.ram_sel   = (nxt_state.xsel == mmd_pkg::MMD_XSEL_RAM); // [R8]
    nxt_state.iocfg_sel = (nxt_state.xsel == mmd_pkg::MMD_XSEL_IOCFG); // [R10]
    nxt_state.pcr_sel   = (nxt_state.xsel == mmd_pkg::MMD_XSEL_PCR); // [R11]
    nxt_state.ciu_sel   = (nxt_state.xsel == mmd_pkg::MMD_XSEL_CIU); // [R12]
    // Read data returns one cycle after the select; zero when unmapped
    nxt_state.xrdata = (state_ff.xsel == mmd_pkg::MMD_XSEL_NONE)
                       ? 8'h00 : extended_ram_space_rdata_in; // [R21]

    // Program fetch
    nxt_state.rom_addr = fetch_addr_in;
    nxt_state.rom_sel  = fetch_req_in && (fetch_addr_in <= `MMD_ROM_END); // [R15]
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff                    <= '0;
      state_ff.power_control_reg  <= `MMD_PCR_RESET; // [R18]
      state_ff.ext_page_high_byte <= `MMD_PAGE_RESET;
      state_ff.pwr                <= mmd_pkg::MMD_RUN;
      state_ff.xsel               <= mmd_pkg::MMD_XSEL_NONE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign internal_data_space_lower_sel_out = state_ff.lower_sel;
  assign internal_data_space_upper_sel_out = state_ff.upper_sel;
  assign special_sel_out     = state_ff.special_sel;
  assign internal_data_space_addr_out      = state_ff.iaddr;
  assign internal_data_space_we_out        = state_ff.iwe;
  assign internal_data_space_wdata_out     = state_ff.iwdata;
  assign special_rdata_out   = state_ff.srdata;
  assign extended_ram_space_addr_out       = state_ff.xaddr;
  assign extended_ram_space_ram_sel_out    = state_ff.ram_sel;
  assign extended_ram_space_iocfg_sel_out  = state_ff.iocfg_sel;
  assign extended_ram_space_pcr_sel_out    = state_ff.pcr_sel;
  assign extended_ram_space_ciu_sel_out    = state_ff.ciu_sel;
  assign extended_ram_space_we_out         = state_ff.xwe;
  assign extended_ram_space_wdata_out      = state_ff.xwdata;
  assign extended_ram_space_rdata_out      = state_ff.xrdata;
  assign rom_sel_out         = state_ff.rom_sel;
  assign rom_addr_out        = state_ff.rom_addr;
  assign baud_double_out     = state_ff.power_control_reg[`MMD_PCR_BAUD_BIT]; // [R16]
  assign cpu_power_down_out  = state_ff.pd; // [R17]

endmodule
`default_nettype wire

// ### test/mmd_assertions.sv
// Port relation checker for the memory map decoder
`timescale 1ns/1ns
`default_nettype none
module mmd_checker (
  input wire logic        clk_sys_in,
  input wire logic        arst_n_in,
  input wire logic        internal_data_space_req_in,
  input wire logic        internal_data_space_we_in,
  input wire logic        internal_data_space_indirect_in,
  input wire logic [7:0]  internal_data_space_field_in,
  input wire logic [7:0]  internal_data_space_ptr_in,
  input wire logic [7:0]  internal_data_space_wdata_in,
  input wire logic        extended_ram_space_req_in,
  input wire logic        extended_ram_space_paged_in,
  input wire logic [15:0] data_pointer_16_in,
  input wire logic [7:0]  extended_ram_space_rdata_in,
  input wire logic        fetch_req_in,
  input wire logic [15:0] fetch_addr_in,
  input wire logic        irq_enabled_in,
  input wire logic        internal_data_space_lower_sel_out,
  input wire logic        internal_data_space_upper_sel_out,
  input wire logic        special_sel_out,
  input wire logic [7:0]  internal_data_space_addr_out,
  input wire logic [15:0] extended_ram_space_addr_out,
  input wire logic        extended_ram_space_ram_sel_out,
  input wire logic        extended_ram_space_iocfg_sel_out,
  input wire logic        extended_ram_space_pcr_sel_out,
  input wire logic        extended_ram_space_ciu_sel_out,
  input wire logic        extended_ram_space_we_out,
  input wire logic [7:0]  extended_ram_space_rdata_out,
  input wire logic        rom_sel_out,
  input wire logic        baud_double_out,
  input wire logic        cpu_power_down_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic       dp_req;
  logic       pcr_wr;
  logic [7:0] ea;
  assign ea = internal_data_space_indirect_in ? internal_data_space_ptr_in : internal_data_space_field_in;
  assign dp_req = extended_ram_space_req_in && !extended_ram_space_paged_in;
  assign pcr_wr = internal_data_space_req_in && internal_data_space_we_in && !internal_data_space_indirect_in && internal_data_space_field_in == 8'h87;
  a_lower_ram: assert property (internal_data_space_req_in && !ea[7] |=> internal_data_space_lower_sel_out)
    else $error("lower ram not selected");
  a_direct_special: assert property (internal_data_space_req_in && !internal_data_space_indirect_in && ea[7]
    |=> special_sel_out && internal_data_space_addr_out == $past(internal_data_space_field_in)) else $error("direct miss");
  a_indirect_upper: assert property (internal_data_space_req_in && internal_data_space_indirect_in && ea[7]
    |=> internal_data_space_upper_sel_out && !special_sel_out && internal_data_space_addr_out == $past(internal_data_space_ptr_in))
    else $error("indirect miss");
  a_ptr_addr: assert property (dp_req |=> extended_ram_space_addr_out == $past(data_pointer_16_in))
    else $error("pointer address wrong");
  a_ram_valid: assert property (dp_req && data_pointer_16_in <= 16'h03C7 |=> extended_ram_space_ram_sel_out)
    else $error("valid ram not selected");
  a_pcr_region: assert property (dp_req && data_pointer_16_in[15:8] == 8'h62
    |=> extended_ram_space_pcr_sel_out && !extended_ram_space_ram_sel_out) else $error("power region miss");
  a_reserved_quiet: assert property (dp_req && data_pointer_16_in inside
    {[16'h03C8:16'h60FF], [16'h6340:16'hFFFF]} |=> !(extended_ram_space_ram_sel_out || extended_ram_space_iocfg_sel_out
    || extended_ram_space_pcr_sel_out || extended_ram_space_ciu_sel_out || extended_ram_space_we_out)) else $error("reserved selected");
  a_rdata_pass: assert property (extended_ram_space_ram_sel_out |=> extended_ram_space_rdata_out == $past(extended_ram_space_rdata_in))
    else $error("read data not passed");
  a_rom_map: assert property (fetch_req_in |=> rom_sel_out == ($past(fetch_addr_in) <= 16'hAFFF))
    else $error("rom select wrong");
  a_baud_write: assert property (pcr_wr |=> baud_double_out == $past(internal_data_space_wdata_in[7]))
    else $error("baud bit wrong");
  a_pd_enter: assert property (pcr_wr && internal_data_space_wdata_in[1] && !irq_enabled_in
    |=> cpu_power_down_out) else $error("no power-down");
  a_wake_up: assert property (irq_enabled_in |=> !cpu_power_down_out)
    else $error("no wake");
endmodule
bind mmd_top mmd_checker u_chk (.*);
`default_nettype wire

// ### test/mmd_xmem_model.sv
// Far-side memory model answering extended reads
`timescale 1ns/1ns
`default_nettype none
module mmd_xmem_model (
  input  wire logic       clk_sys_in,
  input  wire logic       sel_in,
  input  wire logic [7:0] addr_lo_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] junk_ff = 8'hC3;
  // Unselected bus churns so a stale value never passes
  always @(posedge clk_sys_in) junk_ff <= junk_ff + 8'h3B;
  assign rdata_out = sel_in ? addr_lo_in ^ 8'h5A : junk_ff;
endmodule
`default_nettype wire

// ### test/mcu_memory_map_decode_test.sv
// Directed bench for the memory map decoder
`timescale 1ns/1ns
`default_nettype none
module mcu_memory_map_decode_test;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0;
  logic internal_data_space_req_in, internal_data_space_we_in, internal_data_space_indirect_in, extended_ram_space_req_in, extended_ram_space_we_in, extended_ram_space_paged_in;
  logic extended_ram_space_ptr_sel_in, fetch_req_in, irq_enabled_in, internal_data_space_we_out, extended_ram_space_we_out, rom_sel_out;
  logic internal_data_space_lower_sel_out, internal_data_space_upper_sel_out, special_sel_out, extended_ram_space_ram_sel_out;
  logic extended_ram_space_iocfg_sel_out, extended_ram_space_pcr_sel_out, extended_ram_space_ciu_sel_out, baud_double_out;
  logic cpu_power_down_out;
  logic [7:0] internal_data_space_field_in, internal_data_space_ptr_in, internal_data_space_wdata_in, pointer_reg_zero_in;
  logic [7:0] pointer_reg_one_in, extended_ram_space_wdata_in, extended_ram_space_rdata_in, internal_data_space_addr_out;
  logic [7:0] internal_data_space_wdata_out, special_rdata_out, extended_ram_space_wdata_out, extended_ram_space_rdata_out;
  logic [15:0] data_pointer_16_in, fetch_addr_in, extended_ram_space_addr_out, rom_addr_out;
  logic [7:0] ia [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  logic [15:0] fa [3] = '{16'h0000, 16'hAFFF, 16'hB000};
  logic [15:0] xa [14] = '{16'h0000, 16'h03C7, 16'h03C8, 16'h5FFF, 16'h6000, 16'h60FF,
    16'h6100, 16'h61FF, 16'h6200, 16'h62FF, 16'h6300, 16'h633F, 16'h6340, 16'hFFFF};
  logic [3:0] xs [14] = '{4'h8, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h2, 4'h2,
    4'h1, 4'h1, 4'h0, 4'h0};
  int miscompares = 0, num_checks = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  mmd_top DUT (.*);
  mmd_xmem_model u_mem (.clk_sys_in(clk_sys_in), .addr_lo_in(extended_ram_space_addr_out[7:0]),
    .sel_in(extended_ram_space_ram_sel_out | extended_ram_space_iocfg_sel_out | extended_ram_space_pcr_sel_out | extended_ram_space_ciu_sel_out),
    .rdata_out(extended_ram_space_rdata_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // The unused address source carries the inverse so a swapped mux shows
  task automatic id_acc(input logic ind, we, input logic [7:0] a, d, input logic [2:0] sel);
    @(negedge clk_sys_in);
    {internal_data_space_req_in, internal_data_space_indirect_in, internal_data_space_we_in, internal_data_space_wdata_in} = {1'b1, ind, we, d};
    internal_data_space_ptr_in = ind ? a : ~a;
    internal_data_space_field_in = ind ? ~a : a;
    @(negedge clk_sys_in);
    internal_data_space_req_in = 1'b0;
    chk({internal_data_space_lower_sel_out, internal_data_space_upper_sel_out, special_sel_out}, sel);
    chk(internal_data_space_addr_out, a);
    chk({internal_data_space_we_out, internal_data_space_wdata_out}, {we, d});
  endtask
  task automatic x_acc(input logic pg, ps, we, input logic [15:0] a, input logic [3:0] sel);
    @(negedge clk_sys_in);
    {extended_ram_space_req_in, extended_ram_space_paged_in, extended_ram_space_ptr_sel_in, extended_ram_space_we_in} = {1'b1, pg, ps, we};
    data_pointer_16_in = pg ? ~a : a;
    pointer_reg_zero_in = ps ? ~a[7:0] : a[7:0];
    pointer_reg_one_in = ps ? a[7:0] : ~a[7:0];
    extended_ram_space_wdata_in = a[15:8];
    @(negedge clk_sys_in);
    extended_ram_space_req_in = 1'b0;
    chk({extended_ram_space_ram_sel_out, extended_ram_space_iocfg_sel_out, extended_ram_space_pcr_sel_out, extended_ram_space_ciu_sel_out,
      extended_ram_space_we_out}, {sel, we && sel != 4'h0});
    chk(extended_ram_space_addr_out, a);
    chk(extended_ram_space_wdata_out, a[15:8]);
    @(negedge clk_sys_in);
    chk(extended_ram_space_rdata_out, sel != 4'h0 ? a[7:0] ^ 8'h5A : 8'h00);
  endtask
  initial begin
    #4000;
    miscompares++;
    test_done;
  end
  initial begin
    {internal_data_space_req_in, internal_data_space_we_in, internal_data_space_indirect_in, extended_ram_space_req_in, extended_ram_space_we_in} = '0;
    {extended_ram_space_paged_in, extended_ram_space_ptr_sel_in, fetch_req_in, irq_enabled_in} = '0;
    {internal_data_space_field_in, internal_data_space_ptr_in, internal_data_space_wdata_in, pointer_reg_zero_in} = '0;
    {pointer_reg_one_in, extended_ram_space_wdata_in, data_pointer_16_in, fetch_addr_in} = '0;
    repeat (12) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    id_acc(1'b0, 1'b0, 8'h87, 8'h00, 3'b001);
    chk({special_rdata_out, baud_double_out, cpu_power_down_out}, 10'h000);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
      id_acc(i[0], 1'b0, ia[i/2], 8'h00, !ia[i/2][7] ? 3'b100 : i[0] ? 3'b010 : 3'b001);
    $display("internal space test done");
    id_acc(1'b0, 1'b1, 8'h87, 8'hFE, 3'b001);
    chk({baud_double_out, cpu_power_down_out}, 2'b11);
    id_acc(1'b0, 1'b0, 8'h87, 8'h00, 3'b001);
    chk(special_rdata_out, 8'h82);
    irq_enabled_in = 1'b1;
    @(negedge clk_sys_in);
    irq_enabled_in = 1'b0;
    chk({baud_double_out, cpu_power_down_out}, 2'b10);
    id_acc(1'b0, 1'b1, 8'h87, 8'h00, 3'b001);
    chk(baud_double_out, 1'b0);
    $display("power control test done");
    id_acc(1'b0, 1'b1, 8'hFA, 8'h62, 3'b001);
    id_acc(1'b0, 1'b0, 8'hFA, 8'h00, 3'b001);
    chk(special_rdata_out, 8'h62);
    x_acc(1'b1, 1'b0, 1'b0, 16'h6205, 4'h2);
    x_acc(1'b1, 1'b1, 1'b1, 16'h62F0, 4'h2);
    $display("paged test done");
    for (int i = 0; i < 14; i++)
      x_acc(1'b0, 1'b0, i[0], xa[i], xs[i]);
    $display("extended space test done");
    foreach (fa[i]) begin
      @(negedge clk_sys_in);
      {fetch_req_in, fetch_addr_in} = {1'b1, fa[i]};
      @(negedge clk_sys_in);
      fetch_req_in = 1'b0;
      chk({rom_sel_out, rom_addr_out}, {fa[i] <= 16'hAFFF, fa[i]});
    end
    $display("fetch test done");
    test_done;
  end
endmodule
`default_nettype wire
